// *** hdl/bamu_defines.svh ***
`ifndef BAMU_DEFINES_SVH
`define BAMU_DEFINES_SVH

// Register byte offsets
`define BAMU_OFF_CTRL       8'h00
`define BAMU_OFF_ADDR_HIGH  8'h04
`define BAMU_OFF_ADDR_LOW   8'h08
`define BAMU_OFF_WAKE       8'h0c
`define BAMU_OFF_FLAG_CLR   8'h10
`define BAMU_OFF_IRQ_STAT   8'h14
`define BAMU_OFF_IRQ_MASK   8'h18

// Field positions
`define BAMU_EN_BIT         7
`define BAMU_ACT_BIT        6
`define BAMU_WAKE_BIT       1
`define BAMU_CLR_EN_BIT     7
`define BAMU_IRQ_BRK_BIT    0
`define BAMU_IRQ_WAKE_BIT   1

// Reset values
`define BAMU_RST_BYTE       8'h00
`define BAMU_RST_IRQ        2'h0

// Vector pairs and inserted opcode
`define BAMU_VEC_NORMAL     16'hfffc
`define BAMU_VEC_MONITOR    16'hfefc
`define BAMU_SWI_OPCODE     8'h00

`endif

// *** hdl/bamu_pkg.sv ***
package bamu_pkg;

    typedef enum logic [1:0]
    {
        BAMU_IDLE  = 2'b00,
        BAMU_PEND  = 2'b01,
        BAMU_BREAK = 2'b10
    } bamu_state_t;

    typedef logic [7:0]  bamu_byte_t;
    typedef logic [15:0] bamu_addr_t;

endpackage : bamu_pkg

// *** hdl/bamu_cmp.sv ***
module bamu_cmp
    import bamu_pkg::*;
(
    // Compared values
    input  wire bamu_addr_t bus_addr,
    input  wire bamu_addr_t brk_addr,
    // Qualifiers
    input  wire logic       enable,
    input  wire logic       valid,
    // Result
    output logic            hit
);

    logic [15:0] bit_eq;

    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_bit
            assign bit_eq[i] = ~(bus_addr[i] ^ brk_addr[i]);
        end
    endgenerate

    assign hit = enable & valid & (&bit_eq);

endmodule : bamu_cmp

// *** hdl/bamu_unit.sv ***
`include "bamu_defines.svh"

module bamu_unit
    import bamu_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // CPU core
    input  wire bamu_addr_t  cpu_addr,
    input  wire logic        cpu_pc_addr_valid,
    input  wire logic        cpu_last_cycle,
    input  wire logic        cpu_wait_mode,
    input  wire logic        cpu_stop_mode,
    input  wire logic        cpu_rti_exec,
    output logic             break_req,
    output bamu_byte_t       swi_opcode,
    output bamu_addr_t       break_vector,
    output logic             break_state,
    output logic             stop_wake,
    output logic             wait_wake,
    // System
    input  wire logic        monitor_mode,
    input  wire logic        test_high_voltage,
    output logic             timer_hold,
    output logic             watchdog_disable,
    output logic             status_clear_allow,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    bamu_state_t state_q;
    bamu_byte_t  addr_high_q;
    bamu_byte_t  addr_low_q;
    logic        enable_q;
    logic        active_q;
    logic        wake_q;
    logic        clr_en_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_mask_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        break_req_q;
    bamu_byte_t  swi_opcode_q;
    bamu_addr_t  vector_q;
    logic        break_state_q;
    logic        stop_wake_q;
    logic        wait_wake_q;
    logic        timer_hold_q;
    logic        wdog_dis_q;
    logic        clr_allow_q;
    logic        irq_q;

    logic        hit;
    logic        xfer;
    logic        wr;
    logic        sw_trig;
    logic        trig;
    logic        boundary;
    logic        enter_break;
    logic [1:0]  irq_ev;
    logic [1:0]  irq_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator

    // Not gated by wait mode on purpose
    bamu_cmp u_cmp
    (
        .bus_addr (cpu_addr),
        .brk_addr ({addr_high_q, addr_low_q}),
        .enable   (enable_q),
        .valid    (cpu_pc_addr_valid),
        .hit      (hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    assign xfer = psel & penable & pready_q;
    assign wr   = xfer & pwrite;

    always_comb
    begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        unique case (paddr)
            `BAMU_OFF_CTRL:      prdata_d = {24'h00_0000, enable_q, active_q, 6'h00};
            `BAMU_OFF_ADDR_HIGH: prdata_d = {24'h00_0000, addr_high_q};
            `BAMU_OFF_ADDR_LOW:  prdata_d = {24'h00_0000, addr_low_q};
            `BAMU_OFF_WAKE:      prdata_d = {24'h00_0000, 6'h00, wake_q, 1'b0};
            `BAMU_OFF_FLAG_CLR:  prdata_d = {24'h00_0000, clr_en_q, 7'h00};
            `BAMU_OFF_IRQ_STAT:  prdata_d = {30'h0000_0000, irq_stat_q};
            `BAMU_OFF_IRQ_MASK:  prdata_d = {30'h0000_0000, irq_mask_q};
            default:             pslverr_d = 1'b1;
        endcase
    end

    // Fixed one-cycle access phase; data latched in the setup cycle
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & pslverr_d;
            prdata_q  <= (psel & ~penable & ~pwrite) ? prdata_d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            enable_q    <= 1'b0;
            addr_high_q <= `BAMU_RST_BYTE;
            addr_low_q  <= `BAMU_RST_BYTE;
            clr_en_q    <= 1'b0;
            irq_mask_q  <= `BAMU_RST_IRQ;
        end
        else if (wr)
        begin
            if (paddr == `BAMU_OFF_CTRL)
                enable_q <= pwdata[`BAMU_EN_BIT];
            if (paddr == `BAMU_OFF_ADDR_HIGH)
                addr_high_q <= pwdata[7:0];
            if (paddr == `BAMU_OFF_ADDR_LOW)
                addr_low_q <= pwdata[7:0];
            if (paddr == `BAMU_OFF_FLAG_CLR)
                clr_en_q <= pwdata[`BAMU_CLR_EN_BIT];
            if (paddr == `BAMU_OFF_IRQ_MASK)
                irq_mask_q <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Break sequencing

    assign sw_trig = wr & (paddr == `BAMU_OFF_CTRL) & pwdata[`BAMU_ACT_BIT];
    assign trig    = hit | sw_trig;
    // A halted CPU has no instruction to finish
    assign boundary = cpu_last_cycle | cpu_wait_mode | cpu_stop_mode;
    assign enter_break = ((state_q == BAMU_IDLE) & trig & boundary) |
                         ((state_q == BAMU_PEND) & boundary);

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            state_q <= BAMU_IDLE;
        else
        begin
            unique case (state_q)
                BAMU_IDLE:
                    if (trig)
                        state_q <= boundary ? BAMU_BREAK : BAMU_PEND;
                BAMU_PEND:
                    if (boundary)
                        state_q <= BAMU_BREAK;
                BAMU_BREAK:
                    if (cpu_rti_exec)
                        state_q <= BAMU_IDLE;
                default:
                    state_q <= BAMU_IDLE;
            endcase
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            active_q <= 1'b0;
        else if (trig)
            active_q <= 1'b1;
        else if (wr && paddr == `BAMU_OFF_CTRL && !pwdata[`BAMU_ACT_BIT])
            active_q <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            wake_q <= 1'b0;
        else if (enter_break && (cpu_wait_mode || cpu_stop_mode))
            wake_q <= 1'b1;
        else if (wr && paddr == `BAMU_OFF_WAKE && !pwdata[`BAMU_WAKE_BIT])
            wake_q <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            break_req_q  <= 1'b0;
            stop_wake_q  <= 1'b0;
            wait_wake_q  <= 1'b0;
            swi_opcode_q <= `BAMU_RST_BYTE;
            vector_q     <= `BAMU_VEC_NORMAL;
        end
        else
        begin
            break_req_q  <= enter_break;
            stop_wake_q  <= enter_break & cpu_stop_mode;
            wait_wake_q  <= enter_break & cpu_wait_mode;
            swi_opcode_q <= `BAMU_SWI_OPCODE;
            vector_q     <= monitor_mode ? `BAMU_VEC_MONITOR : `BAMU_VEC_NORMAL;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            break_state_q <= 1'b0;
            timer_hold_q  <= 1'b0;
            wdog_dis_q    <= 1'b0;
            clr_allow_q   <= 1'b1;
        end
        else
        begin
            break_state_q <= (state_q == BAMU_BREAK);
            timer_hold_q  <= (state_q == BAMU_BREAK);
            wdog_dis_q    <= (state_q == BAMU_BREAK) & test_high_voltage;
            clr_allow_q   <= (state_q != BAMU_BREAK) | clr_en_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    assign irq_ev  = {enter_break & (cpu_wait_mode | cpu_stop_mode), enter_break};
    assign irq_clr = (wr && paddr == `BAMU_OFF_IRQ_STAT) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            irq_stat_q <= `BAMU_RST_IRQ;
            irq_q      <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign break_req          = break_req_q;
    assign swi_opcode         = swi_opcode_q;
    assign break_vector       = vector_q;
    assign break_state        = break_state_q;
    assign stop_wake          = stop_wake_q;
    assign wait_wake          = wait_wake_q;
    assign timer_hold         = timer_hold_q;
    assign watchdog_disable   = wdog_dis_q;
    assign status_clear_allow = clr_allow_q;
    assign irq                = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic raw_eq;
    assign raw_eq = cpu_pc_addr_valid & (cpu_addr == {addr_high_q, addr_low_q});

    property p_match_leaves_idle;
        @(posedge clock) disable iff (!rst_b)
        (state_q == BAMU_IDLE) && hit |=> (state_q != BAMU_IDLE);
    endproperty
    a_match_leaves_idle: assert property (p_match_leaves_idle)
        else $error("match did not start break sequence");

    property p_pend_to_req;
        @(posedge clock) disable iff (!rst_b)
        (state_q == BAMU_PEND) && !boundary ##1 boundary |=> break_req_q;
    endproperty
    a_pend_to_req: assert property (p_pend_to_req)
        else $error("pending break not requested at boundary");

    property p_vector;
        @(posedge clock) disable iff (!rst_b)
        break_req_q |->
            (vector_q == ($past(monitor_mode) ? `BAMU_VEC_MONITOR : `BAMU_VEC_NORMAL));
    endproperty
    a_vector: assert property (p_vector)
        else $error("wrong break vector");

    property p_last_cycle;
        @(posedge clock) disable iff (!rst_b)
        (state_q == BAMU_IDLE) && hit && cpu_last_cycle |=> break_req_q ##1 break_state_q;
    endproperty
    a_last_cycle: assert property (p_last_cycle)
        else $error("final-cycle match did not break at once");

    property p_sw_trig;
        @(posedge clock) disable iff (!rst_b)
        (state_q == BAMU_IDLE) && sw_trig |=> active_q && (state_q != BAMU_IDLE);
    endproperty
    a_sw_trig: assert property (p_sw_trig)
        else $error("software trigger ignored");

    property p_rti_ends;
        @(posedge clock) disable iff (!rst_b)
        (state_q == BAMU_BREAK) && cpu_rti_exec |=> ##1 !break_state_q && !timer_hold_q;
    endproperty
    a_rti_ends: assert property (p_rti_ends)
        else $error("return did not end break");

    property p_timer_hold;
        @(posedge clock) disable iff (!rst_b)
        break_req_q |=> timer_hold_q;
    endproperty
    a_timer_hold: assert property (p_timer_hold)
        else $error("timers not held in break");

    property p_wdog;
        @(posedge clock) disable iff (!rst_b)
        ##1 (watchdog_disable == ($past(state_q) == BAMU_BREAK && $past(test_high_voltage)));
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog disable wrong");

    property p_enable_wr;
        @(posedge clock) disable iff (!rst_b)
        wr && (paddr == `BAMU_OFF_CTRL) |=> enable_q == $past(pwdata[`BAMU_EN_BIT]);
    endproperty
    a_enable_wr: assert property (p_enable_wr)
        else $error("enable bit not written");

    property p_active_set;
        @(posedge clock) disable iff (!rst_b)
        hit |=> active_q;
    endproperty
    a_active_set: assert property (p_active_set)
        else $error("active flag not set on match");

    property p_addr_wr;
        @(posedge clock) disable iff (!rst_b)
        wr && (paddr == `BAMU_OFF_ADDR_LOW) |=> addr_low_q == $past(pwdata[7:0]);
    endproperty
    a_addr_wr: assert property (p_addr_wr)
        else $error("break address low not written");

    property p_stop_wake;
        @(posedge clock) disable iff (!rst_b)
        stop_wake_q |-> break_req_q && wake_q;
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("stop exit without break or wake flag");

    property p_clr_block;
        @(posedge clock) disable iff (!rst_b)
        (state_q == BAMU_BREAK) && !clr_en_q |=> !status_clear_allow;
    endproperty
    a_clr_block: assert property (p_clr_block)
        else $error("status clear allowed in break");

    property p_disabled;
        @(posedge clock) disable iff (!rst_b)
        !enable_q && raw_eq && !sw_trig && (state_q == BAMU_IDLE) && !active_q
            |=> !active_q && (state_q == BAMU_IDLE);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled match took effect");

    c_sw_break:   cover property (@(posedge clock) disable iff (!rst_b) sw_trig ##[1:4] break_req_q);
    c_wait_wake:  cover property (@(posedge clock) disable iff (!rst_b) wait_wake_q);
    c_pend_path:  cover property (@(posedge clock) disable iff (!rst_b) state_q == BAMU_PEND);
    c_rti:        cover property (@(posedge clock) disable iff (!rst_b)
                                  (state_q == BAMU_BREAK) && cpu_rti_exec);

endmodule : bamu_unit

// *** sim/bamu_cpu_model.sv ***
module bamu_cpu_model
    import bamu_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Bench control
    input  wire logic [1:0] instr_len,
    input  wire logic       go_wait,
    input  wire logic       go_stop,
    input  wire logic       leave,
    // Break unit side
    input  wire logic       break_req,
    output bamu_addr_t      cpu_addr,
    output logic            cpu_pc_addr_valid,
    output logic            cpu_last_cycle,
    output logic            cpu_wait_mode,
    output logic            cpu_stop_mode,
    output logic            cpu_rti_exec
);
    timeunit 1ns;
    timeprecision 100ps;

    bamu_addr_t pc_q;
    logic [1:0] cyc_q;
    logic       rout_q;
    logic       run_w;

    assign run_w             = !rout_q && !cpu_wait_mode && !cpu_stop_mode;
    assign cpu_last_cycle    = run_w && cyc_q == instr_len - 2'd1;
    // Held fetch address stays visible in wait and stop
    assign cpu_pc_addr_valid = !rout_q && (cyc_q == 2'd0 || !run_w);
    // Routine runs elsewhere; inverted pc, held constant, keeps the bus off the fetch address
    assign cpu_addr          = rout_q ? ~pc_q : pc_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            pc_q          <= 16'h1000;
            cyc_q         <= 2'd0;
            rout_q        <= 1'b0;
            cpu_wait_mode <= 1'b0;
            cpu_stop_mode <= 1'b0;
            cpu_rti_exec  <= 1'b0;
        end
        else
        begin
            cpu_rti_exec <= 1'b0;
            if (break_req)
            begin
                rout_q        <= 1'b1;
                cpu_wait_mode <= 1'b0;
                cpu_stop_mode <= 1'b0;
                cyc_q         <= 2'd0;
            end
            else if (rout_q)
            begin
                // Routine length is up to the bench, so slow exits are tried
                if (leave)
                begin
                    rout_q       <= 1'b0;
                    cpu_rti_exec <= 1'b1;
                end
            end
            else if (cpu_last_cycle)
            begin
                cyc_q         <= 2'd0;
                pc_q          <= pc_q + 16'h0001;
                cpu_wait_mode <= go_wait;
                cpu_stop_mode <= go_stop && !go_wait;
            end
            else if (run_w)
                cyc_q <= cyc_q + 2'd1;
        end
    end
endmodule : bamu_cpu_model

// *** sim/tb_top.sv ***
`include "bamu_defines.svh"

module tb_top
    import bamu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        monitor_mode = 1'b0;
    logic        test_high_voltage = 1'b0;
    logic [1:0]  instr_len = 2'd3;
    logic        go_wait = 1'b0;
    logic        go_stop = 1'b0;
    logic        leave = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, break_req, break_state, stop_wake, wait_wake;
    logic        timer_hold, watchdog_disable, status_clear_allow, irq;
    logic        cpu_pc_addr_valid, cpu_last_cycle, cpu_wait_mode, cpu_stop_mode;
    logic        cpu_rti_exec;
    bamu_byte_t  swi_opcode;
    bamu_addr_t  break_vector, cpu_addr;
    int          n_fail = 0;
    int          cmp_count = 0;

    bamu_unit i_dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cpu_addr, .cpu_pc_addr_valid, .cpu_last_cycle, .cpu_wait_mode,
        .cpu_stop_mode, .cpu_rti_exec, .break_req, .swi_opcode, .break_vector, .break_state,
        .stop_wake, .wait_wake, .monitor_mode, .test_high_voltage, .timer_hold,
        .watchdog_disable, .status_clear_allow, .irq);
    bamu_cpu_model i_cpu (.clock, .rst_b, .instr_len, .go_wait, .go_stop, .leave,
        .break_req, .cpu_addr, .cpu_pc_addr_valid, .cpu_last_cycle, .cpu_wait_mode,
        .cpu_stop_mode, .cpu_rti_exec);

    initial
        forever #10 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task tick;
        @(posedge clock);
        #1;
    endtask : tick

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Slave latency is not assumed; pready or the 20-cycle bound ends the wait
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge clock);
        chk("pready", 32'(n < 20), 32'h1);
        r       = prdata;
        e       = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr

    task rd(input string nm, input logic [7:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, {24'h0, x});
    endtask : rd

    task to_match(input bamu_addr_t t);
        int n;
        #1;
        for (n = 0; n < 500 && !(cpu_pc_addr_valid === 1'b1 && cpu_addr === t); n++)
            tick();
        chk("reach", 32'(n < 500), 32'h1);
    endtask : to_match

    task wait_brk(output int lat, output logic ww, output logic sw);
        #1;
        for (lat = 0; lat < 200 && break_req !== 1'b1; lat++)
            tick();
        ww = wait_wake;
        sw = stop_wake;
    endtask : wait_brk

    task leave_rt;
        int n;
        leave <= 1'b1;
        @(posedge clock);
        leave <= 1'b0;
        for (n = 0; n < 10 && break_state !== 1'b0; n++)
            tick();
        chk("break_end", 32'(break_state), 32'h0);
        chk("timer_run", 32'(timer_hold), 32'h0);
    endtask : leave_rt

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [31:0] r;
        logic        e;
        rd("ctrl", `BAMU_OFF_CTRL, 8'h00);
        rd("addr_hi", `BAMU_OFF_ADDR_HIGH, 8'h00);
        rd("addr_lo", `BAMU_OFF_ADDR_LOW, 8'h00);
        rd("wake", `BAMU_OFF_WAKE, 8'h00);
        rd("clr_ctl", `BAMU_OFF_FLAG_CLR, 8'h00);
        wr(`BAMU_OFF_ADDR_HIGH, 8'ha5);
        rd("addr_hi_rw", `BAMU_OFF_ADDR_HIGH, 8'ha5);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("unmapped", {r[30:0], e}, 32'h1);
        chk("vector", 32'(break_vector), 32'h0000fffc);
        chk("clr_allow", 32'(status_clear_allow), 32'h1);
    endtask : t_reset

    task t_match(input logic [1:0] len, input logic tvh);
        bamu_addr_t t;
        int         lat;
        logic       ww, sw;
        instr_len         <= len;
        test_high_voltage <= tvh;
        t = cpu_addr + 16'h0020;
        wr(`BAMU_OFF_ADDR_HIGH, t[15:8]);
        wr(`BAMU_OFF_ADDR_LOW, t[7:0]);
        wr(`BAMU_OFF_CTRL, 8'h80);
        to_match(t);
        wait_brk(lat, ww, sw);
        chk("latency", 32'(lat), 32'(len));
        chk("vector", 32'(break_vector), 32'h0000fffc);
        chk("opcode", 32'(swi_opcode), 32'h0);
        tick();
        chk("timer_hold", 32'(timer_hold), 32'h1);
        tick();
        chk("wd_off", 32'(watchdog_disable), 32'(tvh));
        rd("active", `BAMU_OFF_CTRL, 8'hc0);
        chk("clr_block", 32'(status_clear_allow), 32'h0);
        wr(`BAMU_OFF_FLAG_CLR, 8'h80);
        tick();
        chk("clr_allow", 32'(status_clear_allow), 32'h1);
        wr(`BAMU_OFF_FLAG_CLR, 8'h00);
        wr(`BAMU_OFF_CTRL, 8'h00);
        rd("cleared", `BAMU_OFF_CTRL, 8'h00);
        leave_rt();
    endtask : t_match

    task t_disabled;
        bamu_addr_t t;
        int         lat;
        logic       ww, sw;
        t = cpu_addr + 16'h0010;
        wr(`BAMU_OFF_ADDR_HIGH, t[15:8]);
        wr(`BAMU_OFF_ADDR_LOW, t[7:0]);
        to_match(t);
        wait_brk(lat, ww, sw);
        chk("no_req", 32'(lat), 32'd200);
        rd("no_flag", `BAMU_OFF_CTRL, 8'h00);
    endtask : t_disabled

    task t_soft;
        int   lat;
        logic ww, sw;
        monitor_mode <= 1'b1;
        wr(`BAMU_OFF_CTRL, 8'h40);
        wait_brk(lat, ww, sw);
        chk("soft_req", 32'(lat < 200), 32'h1);
        chk("vector_mon", 32'(break_vector), 32'h0000fefc);
        rd("soft_flag", `BAMU_OFF_CTRL, 8'h40);
        wr(`BAMU_OFF_CTRL, 8'h00);
        leave_rt();
        monitor_mode <= 1'b0;
    endtask : t_soft

    task t_lowpow(input logic stp);
        bamu_addr_t t;
        int         n, lat;
        logic       ww, sw;
        go_wait <= !stp;
        go_stop <= stp;
        for (n = 0; n < 50 && !(cpu_wait_mode === 1'b1 || cpu_stop_mode === 1'b1); n++)
            tick();
        go_wait <= 1'b0;
        go_stop <= 1'b0;
        t = cpu_addr;
        wr(`BAMU_OFF_ADDR_HIGH, t[15:8]);
        wr(`BAMU_OFF_ADDR_LOW, t[7:0]);
        wr(`BAMU_OFF_CTRL, stp ? 8'h40 : 8'h80);
        wait_brk(lat, ww, sw);
        chk("lp_req", 32'(lat < 200), 32'h1);
        chk("wait_wake", 32'(ww), 32'(!stp));
        chk("stop_wake", 32'(sw), 32'(stp));
        rd("wake_set", `BAMU_OFF_WAKE, 8'h02);
        wr(`BAMU_OFF_WAKE, 8'h00);
        rd("wake_clr", `BAMU_OFF_WAKE, 8'h00);
        wr(`BAMU_OFF_CTRL, 8'h00);
        leave_rt();
    endtask : t_lowpow

    task t_irq;
        rd("irq_stat", `BAMU_OFF_IRQ_STAT, 8'h03);
        chk("irq_masked", 32'(irq), 32'h0);
        wr(`BAMU_OFF_IRQ_MASK, 8'h02);
        tick();
        chk("irq_on", 32'(irq), 32'h1);
        wr(`BAMU_OFF_IRQ_STAT, 8'h02);
        tick();
        chk("irq_off", 32'(irq), 32'h0);
        rd("irq_left", `BAMU_OFF_IRQ_STAT, 8'h01);
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_match(2'd3, 1'b1);
        t_match(2'd1, 1'b0);
        t_disabled();
        t_soft();
        t_lowpow(1'b0);
        t_lowpow(1'b1);
        t_irq();
        test_done();
    end

    // Whole run needs well under a thousand cycles; this 20000-cycle limit is far beyond it
    initial
    begin
        #400000;
        n_fail++;
        $display("ERROR run_time expected finish seen timeout");
        test_done();
    end
endmodule : tb_top
